/* rtl/sdmr_pkg.sv */
/*
 * constants, field positions and state codes for the mode register
 * configuration block of a low-voltage double-data-rate sdram.
 * assumes a single command clock and mode-register-set commands that
 * arrive as a bank select plus an address word on that clock.
 */
package sdmr_pkg;
    // ----------------------------------------------------------------
    // command targets
    // ----------------------------------------------------------------
    localparam logic [2:0] BANK_MODE_ZERO = 3'h0;  // mode_register_zero
    localparam logic [2:0] BANK_MODE_ONE = 3'h1;   // mode_register_one

    // ----------------------------------------------------------------
    // mode_register_zero field positions
    // ----------------------------------------------------------------
    localparam int MR0_RL_LO = 4;      // read latency low bit
    localparam int MR0_RL_HI = 6;      // read latency high bit
    localparam int MR0_RL_EXT = 2;     // read latency extension bit
    localparam int MR0_DLL_RST = 8;    // self-clearing loop reset

    // ----------------------------------------------------------------
    // mode_register_one field positions
    // ----------------------------------------------------------------
    localparam int MR1_DLL_OFF = 0;    // 1 disables the loop
    localparam int MR1_DRV_LO = 1;     // drive strength low bit
    localparam int MR1_RTT_LO = 2;     // nominal_termination bit 0
    localparam int MR1_AL_LO = 3;      // additive latency low bit
    localparam int MR1_AL_HI = 4;      // additive latency high bit
    localparam int MR1_DRV_HI = 5;     // drive strength high bit
    localparam int MR1_RTT_MID = 6;    // nominal_termination bit 1
    localparam int MR1_WR_LEVEL = 7;   // write leveling enable
    localparam int MR1_RTT_HI = 9;     // nominal_termination bit 2
    localparam int MR1_TSTROBE = 11;   // termination_strobe enable
    localparam int MR1_QOFF = 12;      // output disable

    // ----------------------------------------------------------------
    // latency values
    // ----------------------------------------------------------------
    localparam logic [4:0] RL_BASE = 5'h04;   // code offset to clocks
    localparam logic [4:0] RL_MIN = 5'h05;    // least read_latency
    localparam logic [4:0] RL_MAX = 5'h0e;    // largest read_latency
    localparam logic [3:0] RL_RESET = 4'h5;   // read_latency after reset
    localparam int PIPE_DEPTH = 32;           // covers additive + read

    // additive latency codes
    typedef enum logic [1:0] {
        AL_ZERO = 2'b00,
        AL_RL_MINUS1 = 2'b01,
        AL_RL_MINUS2 = 2'b10
    } sdmr_al_t;

    // ----------------------------------------------------------------
    // nominal_termination codes: divisor of calibration_resistor
    // ----------------------------------------------------------------
    localparam logic [2:0] RTT_OFF = 3'h0;
    localparam logic [2:0] RTT_DIV4 = 3'h1;
    localparam logic [2:0] RTT_DIV2 = 3'h2;
    localparam logic [2:0] RTT_DIV6 = 3'h3;
    localparam logic [2:0] RTT_DIV12 = 3'h4;
    localparam logic [2:0] RTT_DIV8 = 3'h5;

    // ----------------------------------------------------------------
    // timing counts in clock cycles
    // ----------------------------------------------------------------
    localparam int DLL_LOCK_CYCLES = 512;     // loop relock time
    localparam logic [2:0] BURST_CLOCKS = 3'h4;  // eight beats, two a clock

    // loop state
    typedef enum logic [1:0] {
        DLL_OFF = 2'b00,
        DLL_LOCKING = 2'b01,
        DLL_RUN = 2'b10,
        DLL_SELF_REF = 2'b11
    } sdmr_dll_t;
endpackage : sdmr_pkg

/* rtl/sdmr_config.sv */
/*
 * mode register zero/one configuration logic of a ddr sdram device:
 * read latency, additive latency, loop control, drive strength, output
 * disable, termination strobe, nominal termination and write leveling.
 * assumes all command inputs and the termination pin are synchronous
 * to clk (the device command clock) and the controller keeps its own
 * sequencing duties.
 */
// Overview of operation
// - read latency taken from mode_register_zero field
// - read latency only whole clocks 5..14
// - first data at edge n plus latency
// - mode_register_one holds until rewrite or reset
// - write leveling with outputs on limits usable termination values
// - bit zero of mode_register_one controls loop
// - self refresh stops loop, exit relocks it unless bit zero disabled it meanwhile
// - two bits select output drive strength
// - output disable tristates data and strobes
// - termination strobe replaces data mask on x8
// - three bits choose nominal termination divisor
// - termination pin switches enabled termination
// - bit seven enters write leveling
// - additive latency zero, latency-1 or latency-2
// - loop reset self-clears, 512 clocks to lock
`timescale 1ns/1ps
`default_nettype none

module sdmr_config #(
    parameter bit IS_X8 = 1'b1  // device organised as x8
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // mode register set command
    input wire logic mrsValid,
    input wire logic [2:0] mrsBank,
    input wire logic [15:0] mrsAddr,
    // operations
    input wire logic readCmd,
    input wire logic selfRefEnter,
    input wire logic selfRefExit,
    input wire logic odtPin,
    // configuration view
    output logic [3:0] readLatency,
    output logic [4:0] totalLatency,
    output logic [1:0] driveStrength,
    output logic [2:0] nominalTermination,
    output logic writeLeveling,
    output logic dllRunning,
    output logic dllLocking,
    // data path control
    output logic firstData,
    output logic dataOutEn,
    output logic terminationOn,
    output logic terminationStrobeOn,
    output logic writeDataMaskOn
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] rl;                           // read_latency clocks
        logic [1:0] al;                           // additive code
        logic [4:0] total;                        // additive plus read
        logic dllOff;                             // loop disable bit
        logic [1:0] drive;                        // drive strength code
        logic [2:0] rtt;                          // termination code
        logic wrLevel;                            // write leveling
        logic tstrobe;                            // termination strobe bit
        logic qOff;                               // output disable bit
        logic selfRef;                            // in self refresh
        sdmr_pkg::sdmr_dll_t dll;                 // loop state
        logic [9:0] dllCnt;                       // relock counter
        logic [sdmr_pkg::PIPE_DEPTH-1:0] pipe;    // read command delay line
        logic first;                              // first data clock
        logic [2:0] burst;                        // clocks left in burst
        logic dqOe;                               // data drivers on
        logic rttOn;                              // termination applied
        logic dllRun;                             // loop locked, output copy
        logic dllLock;                            // loop relocking, output copy
        logic tsOn;                               // termination strobe active
        logic dmOn;                               // write_data_mask active
    } sdmr_state_t;

    sdmr_state_t st_r;   // registered state
    sdmr_state_t st_nxt; // next state

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [4:0] rlCand;    // decoded latency candidate
        logic dllResetReq;     // self-clearing loop reset seen
        logic readBusy;        // read in flight or on the pins
        logic rttAllowed;      // code usable in this mode
        rlCand = 5'h00;
        dllResetReq = 1'b0;
        readBusy = 1'b0;
        rttAllowed = 1'b0;
        st_nxt = st_r;

        // mode_register_zero: latency and loop reset
        if (mrsValid && mrsBank == sdmr_pkg::BANK_MODE_ZERO)
        begin
            rlCand = sdmr_pkg::RL_BASE + {1'b0, mrsAddr[sdmr_pkg::MR0_RL_EXT],
                mrsAddr[sdmr_pkg::MR0_RL_HI:sdmr_pkg::MR0_RL_LO]};
            // reserved codes leave the latency as it was
            if (rlCand >= sdmr_pkg::RL_MIN && rlCand <= sdmr_pkg::RL_MAX)
            begin
                st_nxt.rl = rlCand[3:0];
            end
            // reset bit is a one-shot, never stored
            dllResetReq = mrsAddr[sdmr_pkg::MR0_DLL_RST];
        end

        // mode_register_one: all fields loaded together
        if (mrsValid && mrsBank == sdmr_pkg::BANK_MODE_ONE)
        begin
            st_nxt.dllOff = mrsAddr[sdmr_pkg::MR1_DLL_OFF];
            st_nxt.drive = {mrsAddr[sdmr_pkg::MR1_DRV_HI],
                mrsAddr[sdmr_pkg::MR1_DRV_LO]};
            st_nxt.rtt = {mrsAddr[sdmr_pkg::MR1_RTT_HI], mrsAddr[sdmr_pkg::MR1_RTT_MID],
                mrsAddr[sdmr_pkg::MR1_RTT_LO]};
            st_nxt.wrLevel = mrsAddr[sdmr_pkg::MR1_WR_LEVEL];
            st_nxt.tstrobe = mrsAddr[sdmr_pkg::MR1_TSTROBE];
            st_nxt.qOff = mrsAddr[sdmr_pkg::MR1_QOFF];
            // reserved additive code falls back to zero
            if (mrsAddr[sdmr_pkg::MR1_AL_HI:sdmr_pkg::MR1_AL_LO] == 2'b11)
            begin
                st_nxt.al = sdmr_pkg::AL_ZERO;
            end
            else
            begin
                st_nxt.al = mrsAddr[sdmr_pkg::MR1_AL_HI:sdmr_pkg::MR1_AL_LO];
            end
        end

        // additive plus read latency
        case (st_nxt.al)
            sdmr_pkg::AL_RL_MINUS1: st_nxt.total = {st_nxt.rl, 1'b0} - 5'h01;
            sdmr_pkg::AL_RL_MINUS2: st_nxt.total = {st_nxt.rl, 1'b0} - 5'h02;
            default: st_nxt.total = {1'b0, st_nxt.rl};
        endcase

        // self refresh flag
        if (selfRefEnter)
        begin
            st_nxt.selfRef = 1'b1;
        end
        else if (selfRefExit)
        begin
            st_nxt.selfRef = 1'b0;
        end

        // loop state machine
        st_nxt.dllCnt = 10'h000;
        case (st_r.dll)
            sdmr_pkg::DLL_OFF:
            begin
                // needs enable plus an explicit reset to start
                if (!st_nxt.dllOff && dllResetReq)
                begin
                    st_nxt.dll = sdmr_pkg::DLL_LOCKING;
                end
            end
            sdmr_pkg::DLL_LOCKING:
            begin
                st_nxt.dllCnt = st_r.dllCnt + 10'h001;
                if (st_nxt.dllOff)
                begin
                    st_nxt.dll = sdmr_pkg::DLL_OFF;
                end
                else if (selfRefEnter)
                begin
                    st_nxt.dll = sdmr_pkg::DLL_SELF_REF;
                end
                else if (dllResetReq)
                begin
                    st_nxt.dllCnt = 10'h000;
                end
                else if (st_r.dllCnt == 10'(sdmr_pkg::DLL_LOCK_CYCLES - 1))
                begin
                    st_nxt.dll = sdmr_pkg::DLL_RUN;
                end
            end
            sdmr_pkg::DLL_RUN:
            begin
                if (st_nxt.dllOff)
                begin
                    st_nxt.dll = sdmr_pkg::DLL_OFF;
                end
                else if (selfRefEnter)
                begin
                    st_nxt.dll = sdmr_pkg::DLL_SELF_REF;
                end
                else if (dllResetReq)
                begin
                    st_nxt.dll = sdmr_pkg::DLL_LOCKING;
                end
            end
            sdmr_pkg::DLL_SELF_REF:
            begin
                // only an enabled loop comes here; exit relocks it, or turns it off if the disable bit was set meanwhile
                if (selfRefExit)
                begin
                    st_nxt.dll = st_nxt.dllOff ? sdmr_pkg::DLL_OFF : sdmr_pkg::DLL_LOCKING;
                end
            end
            default:
            begin
                st_nxt.dll = sdmr_pkg::DLL_OFF;
            end
        endcase

        // read command delay line and first data
        st_nxt.pipe = {st_r.pipe[sdmr_pkg::PIPE_DEPTH-2:0], readCmd};
        st_nxt.first = st_r.pipe[5'(st_r.total - 5'h01)];

        // burst length on the pins
        if (st_nxt.first)
        begin
            st_nxt.burst = sdmr_pkg::BURST_CLOCKS;
        end
        else if (st_r.burst != 3'h0)
        begin
            st_nxt.burst = st_r.burst - 3'h1;
        end
        st_nxt.dqOe = (st_nxt.burst != 3'h0) && !st_nxt.qOff;

        // termination: which codes are usable right now
        readBusy = (st_r.pipe != '0) || (st_nxt.burst != 3'h0);
        if (st_nxt.wrLevel && !st_nxt.qOff)
        begin
            // write leveling with outputs on: write values only
            rttAllowed = (st_nxt.rtt == sdmr_pkg::RTT_DIV4) ||
                (st_nxt.rtt == sdmr_pkg::RTT_DIV2) ||
                (st_nxt.rtt == sdmr_pkg::RTT_DIV6);
        end
        else
        begin
            rttAllowed = (st_nxt.rtt != sdmr_pkg::RTT_OFF);
        end
        st_nxt.rttOn = rttAllowed && odtPin && !readBusy && !st_nxt.selfRef;
        // registered copies of decoded outputs
        st_nxt.dllRun = (st_nxt.dll == sdmr_pkg::DLL_RUN);
        st_nxt.dllLock = (st_nxt.dll == sdmr_pkg::DLL_LOCKING);
        st_nxt.tsOn = st_nxt.tstrobe && IS_X8;
        st_nxt.dmOn = !(st_nxt.tstrobe && IS_X8);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= '0;
            st_r.rl <= sdmr_pkg::RL_RESET;
            st_r.total <= {1'b0, sdmr_pkg::RL_RESET};
            st_r.dll <= sdmr_pkg::DLL_OFF;
            st_r.dmOn <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all from flip-flops
    // ----------------------------------------------------------------
    assign readLatency = st_r.rl;
    assign totalLatency = st_r.total;
    assign driveStrength = st_r.drive;
    assign nominalTermination = st_r.rtt;
    assign writeLeveling = st_r.wrLevel;
    assign dllRunning = st_r.dllRun;
    assign dllLocking = st_r.dllLock;
    assign firstData = st_r.first;
    assign dataOutEn = st_r.dqOe;
    assign terminationOn = st_r.rttOn;
    assign terminationStrobeOn = st_r.tsOn;
    assign writeDataMaskOn = st_r.dmOn;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    latency_range_a: assert property (readLatency >= 4'h5 && readLatency <= 4'he)
        else $error("read latency outside 5..14");
    first_data_six_a: assert property ((readCmd && totalLatency == 5'h06 && !mrsValid)
        |-> ##7 firstData)
        else $error("first data not six clocks after read");
    additive_sum_a: assert property ((st_r.al == 2'b10)
        |-> totalLatency == {readLatency, 1'b0} - 5'h02)
        else $error("additive latency sum wrong");
    output_disable_a: assert property (st_r.qOff |-> !dataOutEn ##1 !dataOutEn)
        else $error("outputs driven while disabled");
    burst_length_a: assert property ($rose(dataOutEn) |-> dataOutEn[*4] ##1 !dataOutEn)
        else $error("read burst not four clocks");
    sr_entry_a: assert property ((dllRunning && selfRefEnter && !mrsValid)
        |=> !dllRunning && !dllLocking)
        else $error("loop still on in self refresh");
    sr_exit_a: assert property ((st_r.dll == sdmr_pkg::DLL_SELF_REF && selfRefExit)
        |=> dllLocking)
        else $error("loop not relocking after self refresh");
    lock_time_a: assert property ($rose(dllRunning)
        |-> $past(st_r.dllCnt) == 10'(sdmr_pkg::DLL_LOCK_CYCLES - 1))
        else $error("loop locked early");
    level_rtt_a: assert property ((terminationOn && writeLeveling && !st_r.qOff)
        |-> nominalTermination inside {3'h1, 3'h2, 3'h3})
        else $error("termination value not allowed in leveling");
    tstrobe_mask_a: assert property ((mrsValid && mrsBank == 3'h1 && mrsAddr[11])
        |=> terminationStrobeOn == IS_X8 && writeDataMaskOn != IS_X8)
        else $error("termination strobe and mask disagree");
    rtt_pin_a: assert property ((terminationOn) |-> $past(odtPin))
        else $error("termination on without pin");
    dll_bit_a: assert property ((mrsValid && mrsBank == 3'h1 && mrsAddr[0])
        |=> !dllRunning && !dllLocking)
        else $error("loop not stopped by disable bit");
endmodule : sdmr_config

`default_nettype wire

/* testbench/sdmr_ctrl_model.sv */
/*
 * controller-side model: issues mode register set commands on request.
 * assumes the device samples the command bus on the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module sdmr_ctrl_model #(
    parameter bit IS_X8 = 1'b1,  // device organised as x8
    parameter int MOD_WAIT = 12  // quiet cycles after each command
) (
    // clock
    input wire logic clk,
    // command bus
    output var logic mrsValid,
    output var logic [2:0] mrsBank,
    output var logic [15:0] mrsAddr
);
    // ------------------------------------------------------------
    // command driver
    // ------------------------------------------------------------
    // bus idle from time zero
    initial
    begin
        mrsValid = 1'b0;
        mrsBank = 3'h7;
        mrsAddr = 16'hffff;
    end

    // one command, then the mode delays before anything else
    task automatic mode_register_set_command(input logic [2:0] bank, input logic [15:0] addr);
        logic [15:0] a;
        begin
            a = addr;
            if (bank == 3'h0)
                a = a & 16'h1f7f;
            if (bank == 3'h1)
                a = a & (IS_X8 ? 16'h1aff : 16'h12ff);
            @(negedge clk);
            mrsValid = 1'b1;
            mrsBank = bank;
            mrsAddr = a;
            @(negedge clk);
            mrsValid = 1'b0;
            // released lines no longer show the last value
            mrsBank = ~bank;
            mrsAddr = ~a;
            repeat (MOD_WAIT) @(negedge clk);
        end
    endtask : mode_register_set_command
endmodule : sdmr_ctrl_model

`default_nettype wire

/* testbench/sdmr_config_tb_top.sv */
/*
 * self-checking bench for the mode register configuration block.
 * assumes the controller model drives all mode register commands.
 */
`timescale 1ns/1ps
`default_nettype none

module sdmr_config_tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] bank;
        logic [15:0] addr;
        logic [3:0] rl;
        logic [4:0] tot;
        logic [1:0] drv;
        logic [2:0] rtt;
        logic lev;
        logic ts;
    } sdmr_row_t;
    logic clk, nrst, mrsValid, readCmd, selfRefEnter, selfRefExit, odtPin;
    logic [2:0] mrsBank;
    logic [15:0] mrsAddr;
    logic [3:0] readLatency;
    logic [4:0] totalLatency;
    logic [1:0] driveStrength;
    logic [2:0] nominalTermination;
    logic writeLeveling, dllRunning, dllLocking, firstData, dataOutEn;
    logic terminationOn, terminationStrobeOn, writeDataMaskOn;
    int errors = 0;
    int totalChecks = 0;
    int cyc = 0;  // rising edges seen
    // command, then expected configuration view
    sdmr_row_t rows [16] = '{
        '{3'h0, 16'h0010, 4'h5, 5'h05, 2'h0, 3'h0, 1'b0, 1'b0},
        '{3'h1, 16'h0008, 4'h5, 5'h09, 2'h0, 3'h0, 1'b0, 1'b0},
        '{3'h0, 16'h0070, 4'hb, 5'h15, 2'h0, 3'h0, 1'b0, 1'b0},
        '{3'h1, 16'h0010, 4'hb, 5'h14, 2'h0, 3'h0, 1'b0, 1'b0},
        '{3'h1, 16'h0018, 4'hb, 5'h0b, 2'h0, 3'h0, 1'b0, 1'b0},
        '{3'h0, 16'h0024, 4'he, 5'h0e, 2'h0, 3'h0, 1'b0, 1'b0},
        '{3'h0, 16'h0000, 4'he, 5'h0e, 2'h0, 3'h0, 1'b0, 1'b0},
        '{3'h0, 16'h0034, 4'he, 5'h0e, 2'h0, 3'h0, 1'b0, 1'b0},
        '{3'h2, 16'h0010, 4'he, 5'h0e, 2'h0, 3'h0, 1'b0, 1'b0},
        '{3'h1, 16'h0022, 4'he, 5'h0e, 2'h3, 3'h0, 1'b0, 1'b0},
        '{3'h1, 16'h0004, 4'he, 5'h0e, 2'h0, 3'h1, 1'b0, 1'b0},
        '{3'h1, 16'h0040, 4'he, 5'h0e, 2'h0, 3'h2, 1'b0, 1'b0},
        '{3'h1, 16'h0044, 4'he, 5'h0e, 2'h0, 3'h3, 1'b0, 1'b0},
        '{3'h1, 16'h0200, 4'he, 5'h0e, 2'h0, 3'h4, 1'b0, 1'b0},
        '{3'h1, 16'h0204, 4'he, 5'h0e, 2'h0, 3'h5, 1'b0, 1'b0},
        '{3'h1, 16'h0880, 4'he, 5'h0e, 2'h0, 3'h0, 1'b1, 1'b1}};
    // termination cases: {command word, pin level, expected}
    logic [17:0] tRows [5] = '{{16'h0004, 2'b11}, {16'h0004, 2'b00},
        {16'h0280, 2'b10}, {16'h0084, 2'b11}, {16'h1280, 2'b11}};

    // ------------------------------------------------------------
    // instances and clock
    // ------------------------------------------------------------
    sdmr_config sdmr_config_i (.clk(clk), .nrst(nrst), .mrsValid(mrsValid),
        .mrsBank(mrsBank), .mrsAddr(mrsAddr), .readCmd(readCmd),
        .selfRefEnter(selfRefEnter), .selfRefExit(selfRefExit), .odtPin(odtPin),
        .readLatency(readLatency), .totalLatency(totalLatency),
        .driveStrength(driveStrength), .nominalTermination(nominalTermination),
        .writeLeveling(writeLeveling), .dllRunning(dllRunning),
        .dllLocking(dllLocking), .firstData(firstData), .dataOutEn(dataOutEn),
        .terminationOn(terminationOn), .terminationStrobeOn(terminationStrobeOn),
        .writeDataMaskOn(writeDataMaskOn));
    sdmr_ctrl_model #(.IS_X8(1'b1)) sdmr_ctrl_model_i (.clk(clk),
        .mrsValid(mrsValid), .mrsBank(mrsBank), .mrsAddr(mrsAddr));

    // free clock, 8 ns period
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // edge counter for loop lock time measurement
    always @(posedge clk)
        cyc <= cyc + 1;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        begin
            totalChecks++;
            if (seen !== exp)
            begin
                errors++;
                $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask : check

    // counts, verdict, stop
    task automatic end_sim;
        begin
            $display("checks %0d mismatches %0d", totalChecks, errors);
            if (errors == 0 && totalChecks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask : end_sim

    // reset for five cycles, then reset values
    task automatic resetCheck;
        begin
            nrst = 1'b0;
            repeat (5) @(negedge clk);
            nrst = 1'b1;
            @(negedge clk);
            check(readLatency, 4'h5);
            check(totalLatency, 5'h05);
            check({driveStrength, nominalTermination, writeLeveling}, 6'h00);
            check({terminationStrobeOn, writeDataMaskOn}, 2'b01);
            check({dllRunning, dllLocking, dataOutEn}, 3'h0);
        end
    endtask : resetCheck

    // loop reset command, bounded wait for lock
    task automatic lockLoop;
        int t0;
        int k;
        begin
            t0 = cyc;
            sdmr_ctrl_model_i.mode_register_set_command(3'h0, 16'h0120);
            check(dllLocking, 1'b1);
            k = 0;
            while (dllRunning !== 1'b1 && k < 700)
            begin
                @(negedge clk);
                k++;
            end
            if (k >= 700)
            begin
                check(1'b0, 1'b1);
                end_sim();
            end
            check(16'((cyc - t0) >= 513 && (cyc - t0) <= 515), 1'b1);
        end
    endtask : lockLoop

    // one read; first data time, driver window, termination clash
    task automatic readRun(input logic [4:0] tot, input logic outOn);
        int k;
        int first;
        int on;
        int clash;
        begin
            first = 0;
            on = 0;
            clash = 0;
            @(negedge clk);
            readCmd = 1'b1;
            @(negedge clk);
            readCmd = 1'b0;
            for (k = 1; k <= 40; k++)
            begin
                @(negedge clk);
                if (firstData === 1'b1 && first == 0)
                    first = k;
                if (dataOutEn === 1'b1)
                    on++;
                if (dataOutEn === 1'b1 && terminationOn === 1'b1)
                    clash++;
            end
            if (outOn)
                check(16'(first), {11'h000, tot});
            check(16'(on), outOn ? 16'h0004 : 16'h0000);
            check(16'(clash), 16'h0000);
        end
    endtask : readRun

    // one-cycle self refresh entry or exit
    task automatic srPulse(input logic leave);
        begin
            @(negedge clk);
            selfRefEnter = ~leave;
            selfRefExit = leave;
            @(negedge clk);
            selfRefEnter = 1'b0;
            selfRefExit = 1'b0;
        end
    endtask : srPulse

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        int i;
        nrst = 1'b0;
        readCmd = 1'b0;
        selfRefEnter = 1'b0;
        selfRefExit = 1'b0;
        odtPin = 1'b0;
        resetCheck();
        // table of register writes, no reads meanwhile
        for (i = 0; i < 16; i++)
        begin
            sdmr_ctrl_model_i.mode_register_set_command(rows[i].bank, rows[i].addr);
            check(readLatency, rows[i].rl);
            check(totalLatency, rows[i].tot);
            check(driveStrength, rows[i].drv);
            check(nominalTermination, rows[i].rtt);
            check(writeLeveling, rows[i].lev);
            check({terminationStrobeOn, writeDataMaskOn}, {rows[i].ts, ~rows[i].ts});
        end
        // lock the loop, then reads with termination requested
        sdmr_ctrl_model_i.mode_register_set_command(3'h1, 16'h0004);
        lockLoop();
        odtPin = 1'b1;
        readRun(5'h06, 1'b1);
        sdmr_ctrl_model_i.mode_register_set_command(3'h1, 16'h000c);
        readRun(5'h0b, 1'b1);
        sdmr_ctrl_model_i.mode_register_set_command(3'h1, 16'h1004);
        readRun(5'h06, 1'b0);
        // termination pin and leveling limits
        for (i = 0; i < 5; i++)
        begin
            sdmr_ctrl_model_i.mode_register_set_command(3'h1, tRows[i][17:2]);
            odtPin = tRows[i][1];
            repeat (2) @(negedge clk);
            check(terminationOn, tRows[i][0]);
        end
        // self refresh with the loop running, then disabled
        odtPin = 1'b0;
        sdmr_ctrl_model_i.mode_register_set_command(3'h1, 16'h0004);
        srPulse(1'b0);
        check({dllRunning, dllLocking}, 2'b00);
        srPulse(1'b1);
        check({dllRunning, dllLocking}, 2'b01);
        sdmr_ctrl_model_i.mode_register_set_command(3'h1, 16'h0001);
        check({dllRunning, dllLocking}, 2'b00);
        sdmr_ctrl_model_i.mode_register_set_command(3'h0, 16'h0120);
        check({dllRunning, dllLocking}, 2'b00);
        srPulse(1'b0);
        srPulse(1'b1);
        check({dllRunning, dllLocking}, 2'b00);
        sdmr_ctrl_model_i.mode_register_set_command(3'h1, 16'h0000);
        lockLoop();
        resetCheck();
        end_sim();
    end
endmodule : sdmr_config_tb_top

`default_nettype wire
